// >>> dv/pmr_monitor.sv
`default_nettype none
module pmr_monitor #(
  parameter int PINS = 8
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic i_rready,
  input wire logic [PINS-1:0] i_gpio_data,
  input wire logic [PINS-1:0] i_gpio_dir,
  input wire logic i_can_active,
  input wire logic [1:0] o_sci_route,
  input wire logic [PINS-1:0] o_pad_out,
  input wire logic [PINS-1:0] o_pad_oe,
  input wire logic [PINS-1:0] o_pad_reduced_drive,
  input wire logic [PINS-1:0] o_pad_pull_up,
  input wire logic [PINS-1:0] o_pad_pull_down,
  input wire logic [PINS-1:0] o_pin_is_output
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // bus handshakes
  sequence s_write_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_write_answer;
    ##1 !o_bvalid ##1 o_bvalid;
  endsequence
  a_write_answer: assert property (s_write_taken |-> s_write_answer)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  a_bvalid_holds: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response dropped");
  a_rvalid_holds: assert property (o_rvalid && !i_rready |=> o_rvalid)
    else $error("read data dropped");
  // ==========================================================
  // pad relations; pin 7 has no peripheral so it is pure gpio
  a_pull_exclusive: assert property ((o_pad_pull_up & o_pad_pull_down) == '0)
    else $error("pull up and down together");
  a_drive_output: assert property ((o_pad_reduced_drive & ~o_pin_is_output) == '0)
    else $error("reduced drive on input");
  a_pull_pushpull: assert property (
    (o_pad_oe & o_pad_out & (o_pad_pull_up | o_pad_pull_down)) == '0)
    else $error("pull on push-pull output");
  a_input_idle: assert property ($past(i_rstn) && !$past(i_gpio_dir[7]) |-> !o_pad_oe[7])
    else $error("input pin driven");
  a_high_released: assert property ($past(i_rstn)
    && $past(i_gpio_dir[7] && i_gpio_data[7]) |-> !o_pad_oe[7] || o_pad_out[7])
    else $error("one driven low");
  a_low_driven: assert property ($past(i_rstn)
    && $past(i_gpio_dir[7] && !i_gpio_data[7]) |-> o_pad_oe[7] && !o_pad_out[7])
    else $error("zero not driven low");
  a_can_pull: assert property ($past(i_rstn && i_can_active) |-> !o_pad_pull_down[0])
    else $error("pull-down on can receive pin");
  a_route_code: assert property (o_sci_route != 2'h3)
    else $error("reserved serial route shown");
endmodule
bind pmr_top pmr_monitor #(.PINS(PINS)) mon_u (.i_clock(i_clock), .i_rstn(i_rstn),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .o_rvalid(o_rvalid), .i_rready(i_rready), .i_gpio_data(i_gpio_data),
  .i_gpio_dir(i_gpio_dir), .i_can_active(i_can_active), .o_sci_route(o_sci_route),
  .o_pad_out(o_pad_out), .o_pad_oe(o_pad_oe), .o_pad_reduced_drive(o_pad_reduced_drive),
  .o_pad_pull_up(o_pad_pull_up), .o_pad_pull_down(o_pad_pull_down),
  .o_pin_is_output(o_pin_is_output));
`default_nettype wire

// >>> dv/pmr_pad_model.sv
`default_nettype none
module pmr_pad_model (
  input wire logic i_clock,
  input wire logic [7:0] i_pad_out,
  input wire logic [7:0] i_pad_oe,
  input wire logic [7:0] i_pull_up,
  input wire logic [7:0] i_pull_down,
  input wire logic [7:0] i_ext,
  input wire logic [7:0] i_ext_en,
  output logic [7:0] o_pad_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] last_reg = 8'h00;
  always @(posedge i_clock)
  begin
    last_reg <= o_pad_in;
  end
  // a floating pad toggles so a stale level never looks valid
  always_comb
  begin
    for (int b = 0; b < 8; b++)
    begin
      if (i_pad_oe[b])
        o_pad_in[b] = i_pad_out[b];
      else if (i_ext_en[b])
        o_pad_in[b] = i_ext[b];
      else if (i_pull_up[b] ^ i_pull_down[b])
        o_pad_in[b] = i_pull_up[b];
      else
        o_pad_in[b] = ~last_reg[b];
    end
  end
endmodule
`default_nettype wire

// >>> dv/pmr_top_bench.sv
`default_nettype none
module pmr_top_bench import pmr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] rdr, pe, pps, od, dir, data;
  } pmr_row_t;
  localparam pmr_row_t ROWS [4] = '{'{8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h33, 8'h55},
    '{8'h0F, 8'hF0, 8'hAA, 8'hCC, 8'hF0, 8'h8F}, '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h5A},
    '{8'hF0, 8'h0F, 8'hFF, 8'hF0, 8'h0F, 8'hFF}};
  localparam logic [11:0] OFS [5] = '{PMR_OFS_REDUCED_DRIVE, PMR_OFS_PULL_ENABLE,
    PMR_OFS_PULL_POLARITY, PMR_OFS_OPEN_DRAIN, PMR_OFS_ROUTE};
  localparam logic [7:0] ROUTES [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
  localparam logic [1:0] ROUTE_EXP [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic RX_EXP [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
  logic i_clock, i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_can_active;
  logic i_sci_enable, i_port_s_pin_two, i_port_p_pin_zero, i_spi_enable;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sci_rx, o_spi_on_port_m;
  logic o_can_rx;
  logic [11:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd_data;
  logic [3:0] i_spi_out, i_spi_oe, o_spi_in;
  logic [1:0] o_bresp, o_rresp, o_sci_route, rd_resp, wr_resp;
  logic [7:0] i_gpio_data, i_gpio_dir, i_pad_in, o_pad_out, o_pad_oe, o_pad_reduced_drive;
  logic [7:0] o_pad_pull_up, o_pad_pull_down, ext, ext_en, pen, o_pin_is_output;
  int miscompares = 0;
  int tests_run = 0;
  pmr_top dut_u (.i_clock, .i_rstn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_gpio_data,
    .i_gpio_dir, .i_can_active, .i_can_tx(1'h0), .o_can_rx, .i_sci_enable,
    .i_sci_tx(1'h1), .o_sci_rx, .o_sci_route, .i_port_s_pin_two, .i_port_p_pin_zero,
    .i_spi_enable, .i_spi_out, .i_spi_oe, .o_spi_in, .o_spi_on_port_m,
    .i_port_s_spi_in(4'h0), .i_pad_in, .o_pad_out, .o_pad_oe, .o_pad_reduced_drive,
    .o_pad_pull_up, .o_pad_pull_down, .o_pin_is_output);
  pmr_pad_model pad_u (.i_clock, .i_pad_out(o_pad_out), .i_pad_oe(o_pad_oe),
    .i_pull_up(o_pad_pull_up), .i_pull_down(o_pad_pull_down), .i_ext(ext),
    .i_ext_en(ext_en), .o_pad_in(i_pad_in));
  // ==========================================================
  // helpers
  task chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want)
    begin
      miscompares++;
      $display("ERROR %0t: got %h want %h", $time, got, want);
    end
  endtask
  // master waits on handshakes only; the watchdog ends a hang
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic t_aw, t_w, t_b;
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    do
    begin
      @(negedge i_clock);
      t_aw = i_awvalid && o_awready;
      t_w = i_wvalid && o_wready;
      t_b = o_bvalid;
      wr_resp = o_bresp;
      @(posedge i_clock);
      if (t_aw) i_awvalid <= 1'h0;
      if (t_w) i_wvalid <= 1'h0;
    end while (!t_b);
    i_bready <= 1'h0;
  endtask
  task rd(input logic [11:0] a);
    logic t_ar, t_r;
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    do
    begin
      @(negedge i_clock);
      t_ar = i_arvalid && o_arready;
      t_r = o_rvalid;
      rd_data = o_rdata;
      rd_resp = o_rresp;
      @(posedge i_clock);
      if (t_ar) i_arvalid <= 1'h0;
    end while (!t_r);
    i_rready <= 1'h0;
  endtask
  task check_cleared();
    foreach (OFS[k])
    begin
      rd(OFS[k]);
      chk(rd_data, 32'h0);
    end
  endtask
  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // stimulus
  initial
  begin
    i_clock = 1'h0;
    forever #2.5 i_clock = ~i_clock;
  end
  initial
  begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    {i_rstn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_can_active} = '0;
    {i_sci_enable, i_port_s_pin_two, i_port_p_pin_zero, i_spi_enable} = '0;
    {i_awaddr, i_araddr, i_wdata, i_spi_out, i_spi_oe, i_gpio_data, i_gpio_dir} = '0;
    ext = 8'h35;
    ext_en = 8'h00;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'h1;
    check_cleared();
    foreach (ROWS[i])
    begin
      wr(PMR_OFS_REDUCED_DRIVE, ROWS[i].rdr);
      wr(PMR_OFS_PULL_ENABLE, ROWS[i].pe);
      wr(PMR_OFS_PULL_POLARITY, ROWS[i].pps);
      wr(PMR_OFS_OPEN_DRAIN, ROWS[i].od);
      i_gpio_dir <= ROWS[i].dir;
      i_gpio_data <= ROWS[i].data;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      pen = ROWS[i].pe & (~ROWS[i].dir | ROWS[i].od);
      chk(o_pad_oe, ROWS[i].dir & ~(ROWS[i].od & ROWS[i].data));
      chk(o_pad_out & o_pad_oe, ROWS[i].dir & ROWS[i].data & ~ROWS[i].od);
      chk(o_pad_reduced_drive, ROWS[i].rdr & ROWS[i].dir);
      chk(o_pin_is_output, ROWS[i].dir);
      chk(o_pad_pull_up, pen & ~ROWS[i].pps);
      chk(o_pad_pull_down, pen & ROWS[i].pps);
      rd(PMR_OFS_PULL_POLARITY);
      chk(rd_data, ROWS[i].pps);
    end
    // serial routing, rx sources set apart from each other
    ext_en <= 8'hFF;
    i_sci_enable <= 1'h1;
    i_port_s_pin_two <= 1'h1;
    for (int k = 0; k < 4; k++)
    begin
      wr(PMR_OFS_ROUTE, ROUTES[k]);
      chk(wr_resp, PMR_RESP_OKAY);
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk(o_sci_route, ROUTE_EXP[k]);
      chk(o_sci_rx, RX_EXP[k]);
      // port s low: only the port m route still sees a one
      @(posedge i_clock);
      i_port_s_pin_two <= 1'h0;
      repeat (2) @(posedge i_clock);
      @(negedge i_clock);
      chk(o_sci_rx, k == 2);
      rd(PMR_OFS_ROUTE);
      i_port_s_pin_two <= 1'h1;
      chk(rd_data, ROUTES[k]);
    end
    wr(PMR_OFS_ROUTE, 8'h10);
    i_spi_enable <= 1'h1;
    i_spi_out <= 4'hD;
    i_spi_oe <= 4'h2;
    i_can_active <= 1'h1;
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk(o_spi_on_port_m, 1'h1);
    chk(o_spi_in, 4'h5);
    chk(o_pad_oe[5:2], 4'h4);
    chk(o_pad_reduced_drive[5:2], 4'h4);
    chk(o_can_rx, 1'h1);
    chk({o_pad_pull_up[0], o_pad_pull_down[0]}, 2'h0);
    rd(12'h300);
    chk(rd_resp, PMR_RESP_SLVERR);
    chk(rd_data, 32'h0);
    wr(12'h300, 8'hFF);
    chk(wr_resp, PMR_RESP_SLVERR);
    i_rstn <= 1'h0;
    @(posedge i_clock);
    i_rstn <= 1'h1;
    check_cleared();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> rtl/pmr_pkg.sv
`default_nettype none
package pmr_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [11:0] PMR_OFS_REDUCED_DRIVE = 12'h250;
  localparam logic [11:0] PMR_OFS_PULL_ENABLE = 12'h254;
  localparam logic [11:0] PMR_OFS_PULL_POLARITY = 12'h258;
  localparam logic [11:0] PMR_OFS_OPEN_DRAIN = 12'h25C;
  localparam logic [11:0] PMR_OFS_ROUTE = 12'h260;

  // ==========================================================
  // reset values
  localparam logic [7:0] PMR_RST_REG = 8'h00;

  // ==========================================================
  // routing fields
  localparam int PMR_SCI_ROUTE_LSB = 6;
  localparam int PMR_SPI_ROUTE_BIT = 4;
  localparam logic [1:0] PMR_SCI_PORT_S = 2'h0;
  localparam logic [1:0] PMR_SCI_PORT_P = 2'h1;
  localparam logic [1:0] PMR_SCI_PORT_M = 2'h2;

  // ==========================================================
  // port m pin roles
  localparam int PMR_PIN_RX = 0;
  localparam int PMR_PIN_TX = 1;
  // spi slots: 0 master in, 1 master out, 2 serial clock, 3 slave select
  localparam int PMR_SPI_SLOT_OF_PIN [8] = '{-1, -1, 0, 3, 1, 2, -1, -1};

  // ==========================================================
  // axi responses
  localparam logic [1:0] PMR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMR_RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// >>> rtl/pmr_top.sv
// How it works
// [R01] reduced-drive bit one gives about one fifth drive, zero gives full.
// [R02] reduced drive is ignored while the pin is an input.
// [R03] reduced drive applies to gpio and routed peripheral drivers alike.
// [R04] pull-enable bit turns the pull device on or off for input pins.
// [R05] on an output pin the pull acts only in open-drain mode.
// [R06] polarity bit one selects pull-down, zero selects pull-up.
// [R07] while the can unit is active, pull-down on its receive pin is ignored.
// [R08] open-drain bit makes the buffer open-drain whatever function drives it.
// [R09] open-drain drives low for zero and leaves the pin floating for one.
// [R10] open-drain bit has no effect on an input pin.
// [R11] route bits 7:6 put serial tx/rx on port s, port p or port m.
// [R12] reserved serial route code 11 acts like the reset route, port s.
// [R13] route bit 4 moves the spi lines from port s to port m 2,4,5,3.
// [R14] all five registers are readable and writable at any time.
// [R15] a peripheral forcing direction never alters the stored direction bit.
// [R16] every configuration bit clears to zero on reset.
`default_nettype none
module pmr_top
  import pmr_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int PINS = 8
)
(
  input wire logic i_clock,
  input wire logic i_rstn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // general purpose side, stored data and direction
  input wire logic [PINS-1:0] i_gpio_data,
  input wire logic [PINS-1:0] i_gpio_dir,
  // primary can unit
  input wire logic i_can_active,
  input wire logic i_can_tx,
  output logic o_can_rx,
  // second serial interface
  input wire logic i_sci_enable,
  input wire logic i_sci_tx,
  output logic o_sci_rx,
  output logic [1:0] o_sci_route,
  input wire logic i_port_s_pin_two,
  input wire logic i_port_p_pin_zero,
  // primary spi unit, slots: master in, master out, clock, slave select
  input wire logic i_spi_enable,
  input wire logic [3:0] i_spi_out,
  input wire logic [3:0] i_spi_oe,
  output logic [3:0] o_spi_in,
  output logic o_spi_on_port_m,
  input wire logic [3:0] i_port_s_spi_in,
  // port m pads
  input wire logic [PINS-1:0] i_pad_in,
  output logic [PINS-1:0] o_pad_out,
  output logic [PINS-1:0] o_pad_oe,
  output logic [PINS-1:0] o_pad_reduced_drive,
  output logic [PINS-1:0] o_pad_pull_up,
  output logic [PINS-1:0] o_pad_pull_down,
  output logic [PINS-1:0] o_pin_is_output
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [PINS-1:0] reduced_drive;
    logic [PINS-1:0] pull_enable;
    logic [PINS-1:0] pull_polarity;
    logic [PINS-1:0] open_drain;
    logic [7:0] route;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [7:0] w_data;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [PINS-1:0] pad_out;
    logic [PINS-1:0] pad_oe;
    logic [PINS-1:0] pad_rd;
    logic [PINS-1:0] pad_pu;
    logic [PINS-1:0] pad_pd;
    logic [PINS-1:0] pin_out;
    logic can_rx;
    logic sci_rx;
    logic [3:0] spi_in;
  } pmr_state_t;

  pmr_state_t state_reg;
  pmr_state_t state_next;

  // ==========================================================
  // routing decode
  logic [1:0] sci_code;
  logic [1:0] sci_route;
  logic spi_route_m;
  logic sci_on_m;
  logic spi_on_m;

  assign sci_code = state_reg.route[PMR_SCI_ROUTE_LSB+1:PMR_SCI_ROUTE_LSB];
  // reserved code falls back to the reset route
  assign sci_route = (sci_code == PMR_SCI_PORT_M || sci_code == PMR_SCI_PORT_P)
                   ? sci_code : PMR_SCI_PORT_S; // R11 R12
  assign spi_route_m = state_reg.route[PMR_SPI_ROUTE_BIT]; // R13
  assign sci_on_m = i_sci_enable && (sci_route == PMR_SCI_PORT_M);
  assign spi_on_m = i_spi_enable && spi_route_m;

  // ==========================================================
  // per pin function select and pad shaping
  logic [PINS-1:0] fn_sel;
  logic [PINS-1:0] fn_oe;
  logic [PINS-1:0] fn_out;
  logic [PINS-1:0] eff_oe;
  logic [PINS-1:0] eff_out;
  logic [PINS-1:0] nx_pad_out;
  logic [PINS-1:0] nx_pad_oe;
  logic [PINS-1:0] nx_pad_rd;
  logic [PINS-1:0] nx_pad_pu;
  logic [PINS-1:0] nx_pad_pd;

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++)
    begin : g_pin
      localparam int SLOT = (gi < 8) ? PMR_SPI_SLOT_OF_PIN[gi] : -1;
      logic od_active;
      logic pull_on;
      logic pd_blocked;
      if (gi == PMR_PIN_RX)
      begin : g_rx
        // receive pin forced to input by can or serial
        assign fn_sel[gi] = i_can_active || sci_on_m;
        assign fn_oe[gi] = 1'b0;
        assign fn_out[gi] = 1'b0;
      end
      else if (gi == PMR_PIN_TX)
      begin : g_tx
        // can wins over serial when both are enabled
        assign fn_sel[gi] = i_can_active || sci_on_m;
        assign fn_oe[gi] = 1'b1;
        assign fn_out[gi] = i_can_active ? i_can_tx : i_sci_tx;
      end
      else if (SLOT >= 0)
      begin : g_spi
        assign fn_sel[gi] = spi_on_m;
        assign fn_oe[gi] = i_spi_oe[SLOT];
        assign fn_out[gi] = i_spi_out[SLOT];
      end
      else
      begin : g_gpio
        assign fn_sel[gi] = 1'b0;
        assign fn_oe[gi] = 1'b0;
        assign fn_out[gi] = 1'b0;
      end
      // forced direction only overrides, the stored bit is an input here
      assign eff_oe[gi] = fn_sel[gi] ? fn_oe[gi] : i_gpio_dir[gi]; // R15
      assign eff_out[gi] = fn_sel[gi] ? fn_out[gi] : i_gpio_data[gi];
      assign od_active = state_reg.open_drain[gi] && eff_oe[gi]; // R08 R10
      // open-drain: drive low only, release for a one
      assign nx_pad_oe[gi] = eff_oe[gi] && !(od_active && eff_out[gi]); // R09
      assign nx_pad_out[gi] = od_active ? 1'b0 : eff_out[gi]; // R09
      assign nx_pad_rd[gi] = state_reg.reduced_drive[gi] && eff_oe[gi]; // R01 R02 R03
      assign pull_on = state_reg.pull_enable[gi] && (!eff_oe[gi] || od_active); // R04 R05
      assign pd_blocked = (gi == PMR_PIN_RX) && i_can_active; // R07
      assign nx_pad_pu[gi] = pull_on && !state_reg.pull_polarity[gi]; // R06
      assign nx_pad_pd[gi] = pull_on && state_reg.pull_polarity[gi] && !pd_blocked; // R06 R07
    end
  endgenerate

  // ==========================================================
  // register decode
  function automatic logic [2:0] pmr_decode(input logic [ADDR_W-1:0] addr);
    logic [11:0] a;
    a = 12'(addr);
    unique case ({a[11:2], 2'b00})
      PMR_OFS_REDUCED_DRIVE: pmr_decode = 3'h1;
      PMR_OFS_PULL_ENABLE: pmr_decode = 3'h2;
      PMR_OFS_PULL_POLARITY: pmr_decode = 3'h3;
      PMR_OFS_OPEN_DRAIN: pmr_decode = 3'h4;
      PMR_OFS_ROUTE: pmr_decode = 3'h5;
      default: pmr_decode = 3'h0;
    endcase
  endfunction

  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [7:0] rd_byte;

  // one write and one read in flight; each channel waits while it is held
  assign o_awready = !state_reg.aw_held && !state_reg.bvalid;
  assign o_wready = !state_reg.w_held && !state_reg.bvalid;
  assign o_arready = !state_reg.rvalid;
  assign aw_take = i_awvalid && o_awready;
  assign w_take = i_wvalid && o_wready;
  assign ar_take = i_arvalid && o_arready;
  assign do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign wr_sel = pmr_decode(state_reg.aw_addr);
  assign rd_sel = pmr_decode(i_araddr);

  always_comb
  begin
    unique case (rd_sel)
      3'h1: rd_byte = state_reg.reduced_drive; // R14
      3'h2: rd_byte = state_reg.pull_enable;
      3'h3: rd_byte = state_reg.pull_polarity;
      3'h4: rd_byte = state_reg.open_drain;
      3'h5: rd_byte = state_reg.route;
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    state_next = state_reg;
    // write address and data may arrive in either order
    if (aw_take)
    begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = i_awaddr;
    end
    if (w_take)
    begin
      state_next.w_held = 1'b1;
      state_next.w_data = i_wdata[7:0];
      state_next.w_lane = i_wstrb[0];
    end
    if (do_write)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = (wr_sel == 3'h0) ? PMR_RESP_SLVERR : PMR_RESP_OKAY;
      // only the low lane carries register bits
      if (state_reg.w_lane)
      begin
        unique case (wr_sel)
          3'h1: state_next.reduced_drive = state_reg.w_data; // R14
          3'h2: state_next.pull_enable = state_reg.w_data; // R14
          3'h3: state_next.pull_polarity = state_reg.w_data; // R14
          3'h4: state_next.open_drain = state_reg.w_data; // R14
          3'h5: state_next.route = state_reg.w_data; // R14
          default: state_next.bresp = PMR_RESP_SLVERR;
        endcase
      end
    end
    else if (state_reg.bvalid && i_bready)
    begin
      state_next.bvalid = 1'b0;
    end
    if (ar_take)
    begin
      state_next.rvalid = 1'b1;
      state_next.rdata = {24'h000000, rd_byte};
      state_next.rresp = (rd_sel == 3'h0) ? PMR_RESP_SLVERR : PMR_RESP_OKAY;
    end
    else if (state_reg.rvalid && i_rready)
    begin
      state_next.rvalid = 1'b0;
    end
    // pad side, registered so every pad pin leaves a flip-flop
    state_next.pad_out = nx_pad_out;
    state_next.pad_oe = nx_pad_oe;
    state_next.pad_rd = nx_pad_rd;
    state_next.pad_pu = nx_pad_pu;
    state_next.pad_pd = nx_pad_pd;
    state_next.pin_out = eff_oe;
    // peripheral inputs follow the selected route
    state_next.can_rx = i_pad_in[PMR_PIN_RX];
    unique case (sci_route)
      PMR_SCI_PORT_P: state_next.sci_rx = i_port_p_pin_zero; // R11
      PMR_SCI_PORT_M: state_next.sci_rx = i_pad_in[PMR_PIN_RX]; // R11
      default: state_next.sci_rx = i_port_s_pin_two; // R11 R12
    endcase
    state_next.spi_in = spi_route_m
      ? {i_pad_in[3], i_pad_in[5], i_pad_in[4], i_pad_in[2]}
      : i_port_s_spi_in; // R13
  end

  // ==========================================================
  // registers
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      state_reg <= '0;
      state_reg.reduced_drive <= PMR_RST_REG; // R16
      state_reg.pull_enable <= PMR_RST_REG; // R16
      state_reg.pull_polarity <= PMR_RST_REG; // R16
      state_reg.open_drain <= PMR_RST_REG; // R16
      state_reg.route <= PMR_RST_REG; // R16
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // outputs
  assign o_bvalid = state_reg.bvalid;
  assign o_bresp = state_reg.bresp;
  assign o_rvalid = state_reg.rvalid;
  assign o_rdata = state_reg.rdata;
  assign o_rresp = state_reg.rresp;
  assign o_pad_out = state_reg.pad_out;
  assign o_pad_oe = state_reg.pad_oe;
  assign o_pad_reduced_drive = state_reg.pad_rd;
  assign o_pad_pull_up = state_reg.pad_pu;
  assign o_pad_pull_down = state_reg.pad_pd;
  assign o_pin_is_output = state_reg.pin_out;
  assign o_can_rx = state_reg.can_rx;
  assign o_sci_rx = state_reg.sci_rx;
  assign o_sci_route = sci_route;
  assign o_spi_in = state_reg.spi_in;
  assign o_spi_on_port_m = spi_on_m;

endmodule
`default_nettype wire
